// [pm_cfg_pkg.sv]
// Constants, addresses and types shared by the power-mode and readout-format configuration block
package pm_cfg_pkg;

    // Register addresses
    localparam logic [7:0] CFG_ADDR = 8'h16;
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] TEMP_ADDR = 8'h01;
    localparam logic [7:0] OUT_X_ADDR = 8'h04;
    localparam logic [7:0] OUT_LAST_ADDR = 8'h09;
    localparam logic [7:0] MAG_ADDR = 8'h0A;
    localparam logic [7:0] MAG_LAST_ADDR = 8'h0B;
    localparam logic [7:0] BUF_ADDR = 8'h0C;
    localparam logic [7:0] BUF_LAST_ADDR = 8'h11;

    // Field positions in the configuration register
    localparam int AWAKE_PM_HI = 7;
    localparam int AWAKE_PM_LO = 6;
    localparam int DORMANT_PM_HI = 5;
    localparam int DORMANT_PM_LO = 4;
    localparam int BYTE_ORDER_BIT = 3;
    localparam int THERMAL_BURST_BIT = 1;
    localparam int FAST_READ_BIT = 0;

    // Rate register nibbles
    localparam int AWAKE_NIB_HI = 7;
    localparam int AWAKE_NIB_LO = 4;
    localparam int DORMANT_NIB_HI = 3;
    localparam int DORMANT_NIB_LO = 0;

    // Reset values and field codes
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] PM_LOW_CODE = 2'h0;
    localparam logic [1:0] PM_HIGH_CODE = 2'h1;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] ADDR_STEP = 8'h01;
    localparam logic [7:0] FAST_STEP = 8'h02;

    // Power-mode selection, one-hot
    typedef enum logic [2:0] {
        PM_LOW = 3'b001,
        PM_HIGH = 3'b010,
        PM_FLEX = 3'b100
    } power_mode_t;

endpackage

// [sample_byte_format.sv]
// Places one byte of a 12-bit sample according to byte order and fast-read settings
`timescale 1ns/1ps
module sample_byte_format
    import pm_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic upper_byte,
    input wire logic big_endian,
    input wire logic fast_read,
    output logic [7:0] byte_out
);

    // Fast read always puts the top byte at the lower address, whatever the byte order
    always_comb begin
        if (fast_read && !upper_byte) begin
            byte_out = sample[SAMPLE_W-1 -: 8];
        end else if (big_endian) begin
            if (!upper_byte) begin
                byte_out = sample[SAMPLE_W-1 -: 8];
            end else begin
                byte_out = {sample[SAMPLE_W-9:0], NIBBLE_ZERO};
            end
        end else begin
            if (!upper_byte) begin
                byte_out = sample[7:0];
            end else begin
                byte_out = {NIBBLE_ZERO, sample[SAMPLE_W-1:8]};
            end
        end
    end

endmodule // sample_byte_format

// [power_mode_cfg.sv]
// Power-mode and readout-format configuration register with output data read path
`timescale 1ns/1ps
module power_mode_cfg
    import pm_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    output logic [7:0] next_addr_r,
    input wire logic [7:0] rate_decimation_register,
    input wire logic [SAMPLE_W-1:0] accel_x,
    input wire logic [SAMPLE_W-1:0] accel_y,
    input wire logic [SAMPLE_W-1:0] accel_z,
    input wire logic [SAMPLE_W-1:0] vector_magnitude_output,
    input wire logic [SAMPLE_W-1:0] buf_x,
    input wire logic [SAMPLE_W-1:0] buf_y,
    input wire logic [SAMPLE_W-1:0] buf_z,
    input wire logic [7:0] temp_value,
    input wire logic [7:0] status_value,
    output power_mode_t awake_mode_r,
    output power_mode_t dormant_mode_r,
    output logic [3:0] awake_rate_code_r,
    output logic [3:0] awake_decimation_code_r,
    output logic [3:0] dormant_rate_code_r,
    output logic [3:0] dormant_decimation_code_r,
    output logic [7:0] cfg_value_r
);

    // Configuration register and its decode stage
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    power_mode_t awake_mode_nxt;
    power_mode_t dormant_mode_nxt;
    logic [3:0] awake_rate_code_nxt;
    logic [3:0] awake_decimation_code_nxt;
    logic [3:0] dormant_rate_code_nxt;
    logic [3:0] dormant_decimation_code_nxt;

    // Read path
    logic [7:0] reg_rdata_nxt;
    logic [7:0] next_addr_nxt;
    logic [SAMPLE_W-1:0] sel_sample;
    logic sel_upper;
    logic [7:0] fmt_byte;
    logic big_endian;
    logic fast_read;

    // Decode of the two-bit power field; used for both states
    function automatic power_mode_t pm_decode(input logic [1:0] code);
        if (code == PM_LOW_CODE) begin
            pm_decode = PM_LOW;
        end else if (code == PM_HIGH_CODE) begin
            pm_decode = PM_HIGH;
        end else begin
            pm_decode = PM_FLEX;
        end
    endfunction

    // Address lies in a region that follows the byte-order setting
    function automatic logic in_sample_region(input logic [7:0] a);
        in_sample_region = (a >= OUT_X_ADDR && a <= OUT_LAST_ADDR) ||
                           (a >= MAG_ADDR && a <= MAG_LAST_ADDR) ||
                           (a >= BUF_ADDR && a <= BUF_LAST_ADDR);
    endfunction

    // Axis samples whose high byte fast-read bursts skip
    function automatic logic in_axis_region(input logic [7:0] a);
        in_axis_region = (a >= OUT_X_ADDR && a <= OUT_LAST_ADDR) ||
                         (a >= BUF_ADDR && a <= BUF_LAST_ADDR);
    endfunction

    assign big_endian = cfg_r[BYTE_ORDER_BIT];
    assign fast_read = cfg_r[FAST_READ_BIT];

    // Whole-byte write; no field can be seen half updated
    always_comb begin
        cfg_nxt = cfg_r;
        if (reg_wr && reg_addr == CFG_ADDR) begin
            cfg_nxt = reg_wdata;
        end
    end

    // Mode decode runs from the stored byte, so the decoded outputs change one cycle after cfg_value_r
    always_comb begin
        awake_mode_nxt = pm_decode(cfg_r[AWAKE_PM_HI:AWAKE_PM_LO]);
        dormant_mode_nxt = pm_decode(cfg_r[DORMANT_PM_HI:DORMANT_PM_LO]);
        awake_rate_code_nxt = NIBBLE_ZERO;
        awake_decimation_code_nxt = NIBBLE_ZERO;
        dormant_rate_code_nxt = NIBBLE_ZERO;
        dormant_decimation_code_nxt = NIBBLE_ZERO;
        case (awake_mode_nxt)
            PM_LOW: begin
                awake_rate_code_nxt = rate_decimation_register[AWAKE_NIB_HI:AWAKE_NIB_LO];
            end
            PM_HIGH: begin
                awake_rate_code_nxt = rate_decimation_register[AWAKE_NIB_HI:AWAKE_NIB_LO];
            end
            PM_FLEX: begin
                awake_decimation_code_nxt = rate_decimation_register[AWAKE_NIB_HI:AWAKE_NIB_LO];
            end
            default: begin
                awake_rate_code_nxt = NIBBLE_ZERO;
            end
        endcase
        case (dormant_mode_nxt)
            PM_LOW, PM_HIGH: begin
                dormant_rate_code_nxt = rate_decimation_register[DORMANT_NIB_HI:DORMANT_NIB_LO];
            end
            PM_FLEX: begin
                dormant_decimation_code_nxt = rate_decimation_register[DORMANT_NIB_HI:DORMANT_NIB_LO];
            end
            default: begin
                dormant_rate_code_nxt = NIBBLE_ZERO;
            end
        endcase
    end

    // Pick the sample and byte half for the addressed location
    always_comb begin
        sel_sample = accel_x;
        sel_upper = 1'b0;
        if (reg_addr >= OUT_X_ADDR && reg_addr <= OUT_LAST_ADDR) begin
            sel_upper = reg_addr[0];
            case (reg_addr[2:1])
                2'h2: sel_sample = accel_x;
                2'h3: sel_sample = accel_y;
                default: sel_sample = accel_z;
            endcase
        end else if (reg_addr >= MAG_ADDR && reg_addr <= MAG_LAST_ADDR) begin
            sel_upper = reg_addr[0];
            sel_sample = vector_magnitude_output;
        end else if (reg_addr >= BUF_ADDR && reg_addr <= BUF_LAST_ADDR) begin
            sel_upper = reg_addr[0];
            case (reg_addr[2:1])
                2'h2: sel_sample = buf_x;
                2'h3: sel_sample = buf_y;
                default: sel_sample = buf_z;
            endcase
        end
    end

    sample_byte_format #(
        .SAMPLE_W(SAMPLE_W)
    ) u_fmt (
        .sample(sel_sample),
        .upper_byte(sel_upper),
        .big_endian(big_endian),
        .fast_read(fast_read),
        .byte_out(fmt_byte)
    );

    // Read data and burst pointer; unmapped addresses read as zero
    always_comb begin
        reg_rdata_nxt = reg_rdata_r;
        next_addr_nxt = next_addr_r;
        if (reg_rd) begin
            if (reg_addr == CFG_ADDR) begin
                reg_rdata_nxt = cfg_r;
            end else if (reg_addr == STATUS_ADDR) begin
                reg_rdata_nxt = status_value;
            end else if (reg_addr == TEMP_ADDR) begin
                reg_rdata_nxt = temp_value;
            end else if (in_sample_region(reg_addr)) begin
                reg_rdata_nxt = fmt_byte;
            end else begin
                reg_rdata_nxt = BYTE_ZERO;
            end
            if (reg_addr == STATUS_ADDR) begin
                // Temperature sits between status and the first axis only when included
                next_addr_nxt = cfg_r[THERMAL_BURST_BIT] ? TEMP_ADDR : OUT_X_ADDR;
            end else if (fast_read && in_axis_region(reg_addr) && !reg_addr[0]) begin
                next_addr_nxt = reg_addr + FAST_STEP;
            end else begin
                next_addr_nxt = reg_addr + ADDR_STEP;
            end
        end
    end

    // All state registers; synchronous reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
            awake_mode_r <= PM_LOW;
            dormant_mode_r <= PM_LOW;
            awake_rate_code_r <= NIBBLE_ZERO;
            awake_decimation_code_r <= NIBBLE_ZERO;
            dormant_rate_code_r <= NIBBLE_ZERO;
            dormant_decimation_code_r <= NIBBLE_ZERO;
            cfg_value_r <= CFG_RESET;
            reg_rdata_r <= BYTE_ZERO;
            next_addr_r <= BYTE_ZERO;
        end else begin
            cfg_r <= cfg_nxt;
            awake_mode_r <= awake_mode_nxt;
            dormant_mode_r <= dormant_mode_nxt;
            awake_rate_code_r <= awake_rate_code_nxt;
            awake_decimation_code_r <= awake_decimation_code_nxt;
            dormant_rate_code_r <= dormant_rate_code_nxt;
            dormant_decimation_code_r <= dormant_decimation_code_nxt;
            cfg_value_r <= cfg_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            next_addr_r <= next_addr_nxt;
        end
    end

endmodule // power_mode_cfg

// [pm_host_model.sv]
// Host model that issues register strobes toward the configuration block
`timescale 1ns/1ps
module pm_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata_r,
    input wire logic [7:0] next_addr_r,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // Bus idle at time zero
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Rate and mode fields only change here with the sensor idle; no single-wire motion mode is modelled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #2;
        reg_wr = 1'b0;
        reg_addr = ~a; // Released lines show no stale value
        reg_wdata = ~d;
    endtask

    // One read strobe; answer is taken right after the edge that sampled it
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] n);
        @(posedge ref_clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #2;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_r;
        n = next_addr_r;
    endtask
endmodule // pm_host_model

// [power_mode_cfg_chk.sv]
// Port-level assertions for the configuration block
`timescale 1ns/1ps
module power_mode_cfg_chk
    import pm_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic [7:0] next_addr_r,
    input wire logic [SAMPLE_W-1:0] accel_x,
    input wire power_mode_t awake_mode_r,
    input wire power_mode_t dormant_mode_r,
    input wire logic [3:0] awake_rate_code_r,
    input wire logic [3:0] awake_decimation_code_r,
    input wire logic [3:0] dormant_rate_code_r,
    input wire logic [7:0] cfg_value_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Decoded modes trail the stored register by one edge
    property p_wake_low; cfg_value_r[7:6] == 2'h0 |=> awake_mode_r == PM_LOW && awake_decimation_code_r == 4'h0; endproperty
    a_wake_low: assert property (p_wake_low) else $error("awake low-power decode wrong");
    property p_wake_high; cfg_value_r[7:6] == 2'h1 |=> awake_mode_r == PM_HIGH && awake_decimation_code_r == 4'h0; endproperty
    a_wake_high: assert property (p_wake_high) else $error("awake high-perf decode wrong");
    property p_wake_flex; cfg_value_r[7] |=> awake_mode_r == PM_FLEX && awake_rate_code_r == 4'h0; endproperty
    a_wake_flex: assert property (p_wake_flex) else $error("awake flexible decode wrong");
    property p_sleep_std; !cfg_value_r[5] |=> dormant_mode_r == ($past(cfg_value_r[4]) ? PM_HIGH : PM_LOW); endproperty
    a_sleep_std: assert property (p_sleep_std) else $error("dormant standard decode wrong");
    property p_sleep_flex; cfg_value_r[5] |=> dormant_mode_r == PM_FLEX && dormant_rate_code_r == 4'h0; endproperty
    a_sleep_flex: assert property (p_sleep_flex) else $error("dormant flexible decode wrong");
    property p_cfg_wr; reg_wr && reg_addr == CFG_ADDR |=> cfg_value_r == $past(reg_wdata); endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write not stored whole");
    property p_cfg_keep; reg_wr && reg_addr != CFG_ADDR |=> $stable(cfg_value_r); endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("foreign write changed config");
    property p_status_ptr; reg_rd && reg_addr == STATUS_ADDR |=> next_addr_r == ($past(cfg_value_r[1]) ? TEMP_ADDR : OUT_X_ADDR); endproperty
    a_status_ptr: assert property (p_status_ptr) else $error("pointer after status wrong");
    property p_fast_x; reg_rd && cfg_value_r[0] && reg_addr == OUT_X_ADDR |=> reg_rdata_r == 8'($past(accel_x) >> 4) && next_addr_r == OUT_X_ADDR + FAST_STEP; endproperty
    a_fast_x: assert property (p_fast_x) else $error("fast read of X wrong");
    // High X byte follows byte order alone; fast read leaves the upper byte's format untouched
    property p_be_lo; reg_rd && cfg_value_r[3] && reg_addr == OUT_X_ADDR + ADDR_STEP |=> reg_rdata_r == 8'($past(accel_x) << 4); endproperty
    a_be_lo: assert property (p_be_lo) else $error("big-endian low nibble wrong");
    c_flex: cover property (cfg_value_r[7:6] == 2'h2 ##1 awake_mode_r == PM_FLEX);
    c_fast: cover property (reg_rd && cfg_value_r[0]);
    c_be: cover property (reg_rd && cfg_value_r[3]);
    c_thermal: cover property (reg_rd && reg_addr == STATUS_ADDR && cfg_value_r[1]);
endmodule // power_mode_cfg_chk

bind power_mode_cfg power_mode_cfg_chk #(.SAMPLE_W(SAMPLE_W)) chk_i (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_r, .next_addr_r, .accel_x, .awake_mode_r, .dormant_mode_r, .awake_rate_code_r,
    .awake_decimation_code_r, .dormant_rate_code_r, .cfg_value_r);

// [test_power_mode_and_readout_format_config.sv]
// Self-checking bench for the configuration block
`timescale 1ns/1ps
module test_power_mode_and_readout_format_config;
    import pm_cfg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, next_addr_r, rate_decimation_register, temp_value, status_value;
    logic [7:0] cfg_value_r;
    logic [11:0] smp [7];
    logic [3:0] awake_rate_code_r, awake_decimation_code_r, dormant_rate_code_r, dormant_decimation_code_r;
    power_mode_t awake_mode_r, dormant_mode_r;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 84604;
    int cfg = 0;

    power_mode_cfg #(.SAMPLE_W(12)) uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
        .next_addr_r, .rate_decimation_register, .accel_x(smp[0]), .accel_y(smp[1]), .accel_z(smp[2]),
        .vector_magnitude_output(smp[3]), .buf_x(smp[4]), .buf_y(smp[5]), .buf_z(smp[6]), .temp_value,
        .status_value, .awake_mode_r, .dormant_mode_r, .awake_rate_code_r, .awake_decimation_code_r,
        .dormant_rate_code_r, .dormant_decimation_code_r, .cfg_value_r);
    pm_host_model host (.ref_clk, .reg_rdata_r, .next_addr_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    // Expected byte at an address; samples pair even low byte, odd high byte
    function automatic int exp_byte(int a);
        int s;
        if (a == 8'h16) return cfg;
        if (a == 0) return status_value;
        if (a == 1) return temp_value;
        if (a < 4 || a > 8'h11) return 0;
        s = smp[(a - 4) / 2];
        if (a % 2 == 0) return (cfg[0] || cfg[3]) ? s >> 4 : s & 255;
        return cfg[3] ? (s & 15) << 4 : s >> 8;
    endfunction

    // Expected pointer after a read; fast read skips only axis high bytes
    function automatic int exp_next(int a);
        if (a == 0) return cfg[1] ? 1 : 4;
        if (cfg[0] && a % 2 == 0 && ((a >= 4 && a <= 8) || (a >= 12 && a <= 16))) return a + 2;
        return (a + 1) % 256;
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog well beyond the roughly 850 cycles of traffic
    initial begin
        #(25 * 20000);
        n_mismatch++;
        print_verdict;
    end

    // Every power code pair, with byte order and fast read crossed, each followed by a sweep of addresses 0x00 to 0x17
    initial begin
        logic [7:0] d, n;
        int a, k, i;
        rate_decimation_register = 8'h00;
        temp_value = 8'h00;
        status_value = 8'h00;
        for (i = 0; i < 7; i++) smp[i] = 12'h000;
        repeat (3) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        chk(cfg_value_r, 8'h00);
        chk({5'h00, awake_mode_r}, {5'h00, PM_LOW});
        for (k = 0; k < 16; k++) begin
            cfg = (k % 4) * 64 + (k / 4) * 16 + (k % 2) * 8 + (k / 4) % 2 + ($random(seed) & 6);
            rate_decimation_register = 8'($random(seed));
            temp_value = 8'($random(seed));
            status_value = 8'($random(seed));
            for (i = 0; i < 7; i++) smp[i] = 12'($random(seed));
            host.wr(CFG_ADDR, 8'(cfg));
            host.wr(8'h15, ~8'(cfg));
            chk(cfg_value_r, 8'(cfg));
            chk({5'h00, awake_mode_r}, {5'h00, cfg[7] ? PM_FLEX : cfg[6] ? PM_HIGH : PM_LOW});
            chk({5'h00, dormant_mode_r}, {5'h00, cfg[5] ? PM_FLEX : cfg[4] ? PM_HIGH : PM_LOW});
            chk({4'h0, awake_rate_code_r}, cfg[7] ? 8'h00 : {4'h0, rate_decimation_register[7:4]});
            chk({4'h0, awake_decimation_code_r}, cfg[7] ? {4'h0, rate_decimation_register[7:4]} : 8'h00);
            chk({4'h0, dormant_rate_code_r}, cfg[5] ? 8'h00 : {4'h0, rate_decimation_register[3:0]});
            chk({4'h0, dormant_decimation_code_r}, cfg[5] ? {4'h0, rate_decimation_register[3:0]} : 8'h00);
            for (a = 0; a < 8'h18; a++) begin
                host.rd(8'(a), d, n);
                chk(d, 8'(exp_byte(a)));
                chk(n, 8'(exp_next(a)));
            end
        end
        print_verdict;
    end
endmodule // test_power_mode_and_readout_format_config
